// File: core/crm_pkg.sv
// Shared constants and types for the core register bank and data map
package crm_pkg;
   // I/O space offsets (port-instruction addressing)
   localparam logic [5:0] IO_GUARD = 6'h3C;
   localparam logic [5:0] IO_SP_LO = 6'h3D;
   localparam logic [5:0] IO_SP_HI = 6'h3E;
   localparam logic [5:0] IO_STATUS = 6'h3F;
   localparam logic [5:0] IO_MAIN_SRC = 6'h37;
   localparam logic [5:0] IO_PRESCALE = 6'h36;
   localparam logic [5:0] IO_WDOG = 6'h31;
   localparam logic [5:0] IO_BITOP_MAX = 6'h1F;
   localparam logic [5:0] IO_SER_LO = 6'h08;
   localparam logic [5:0] IO_SER_HI = 6'h0F;
   // Unlock signatures and window length in instruction cycles
   localparam logic [7:0] SIG_PROT_IO = 8'hD8;
   localparam logic [7:0] SIG_SELF_PROG = 8'hE7;
   localparam logic [2:0] WINDOW_CYCLES = 3'h4;
   localparam int GUARD_IO_BIT = 0;
   localparam int GUARD_SPM_BIT = 1;
   // Stack pointer
   localparam logic [15:0] SP_RESET = 16'h005F;
   localparam logic [15:0] SP_MASK = 16'h007F;
   // Status flag positions
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_T = 6;
   localparam int FLG_I = 7;
   localparam logic [7:0] ALU_FLAG_MASK = 8'h2F;
   // Data space map (byte addresses)
   localparam logic [15:0] DATA_IO_BASE = 16'h0020;
   localparam logic [15:0] DATA_IO_END = 16'h005F;
   localparam logic [15:0] SRAM_BASE = 16'h0060;
   localparam logic [15:0] SRAM_END = 16'h007F;
   localparam logic [15:0] DIRECT_LO = 16'h0040;
   localparam logic [15:0] DIRECT_HI = 16'h00BF;
   localparam logic [15:0] LOCK_ADDR = 16'h3F00;
   localparam logic [15:0] FLASH_BASE = 16'h4000;
   localparam logic [15:0] FLASH_END = 16'h43FF;
   localparam int PC_WIDTH = 9;
   localparam int ACCESS_CYCLES = 2;
   typedef enum logic [1:0] {ACC_IDLE = 2'b01, ACC_DONE = 2'b10} crm_acc_state_t;
   typedef enum logic [2:0] {G_CLOSED = 3'b001, G_IO_OPEN = 3'b010, G_SPM_OPEN = 3'b100} crm_guard_state_t;
endpackage

// File: core/crm_guard_if.sv
// Signals between the register bank and its unlock window timer
`timescale 1ns/100ps
`default_nettype none
interface crm_guard_if;
   logic wr;
   logic [7:0] wdata;
   logic tick;
   logic io_open;
   logic spm_open;
   modport window (input wr, input wdata, input tick, output io_open, output spm_open);
   modport bank (output wr, output wdata, output tick, input io_open, input spm_open);
endinterface
`default_nettype wire

// File: core/crm_guard_window.sv
// Signature check and four-instruction unlock window
`timescale 1ns/100ps
`default_nettype none
module crm_guard_window import crm_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   crm_guard_if.window gif
);
   crm_guard_state_t st_q, st_d;
   logic [2:0] cnt_q, cnt_d;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      if (gif.wr) begin
         cnt_d = 3'h0;
         // A wrong value closes any open window
         if (gif.wdata == SIG_PROT_IO) begin
            st_d = G_IO_OPEN;
         end else if (gif.wdata == SIG_SELF_PROG) begin
            st_d = G_SPM_OPEN;
         end else begin
            st_d = G_CLOSED;
         end
      end else if (st_q != G_CLOSED && gif.tick) begin
         cnt_d = cnt_q + 3'h1;
         if (cnt_q == WINDOW_CYCLES - 3'h1) begin
            st_d = G_CLOSED;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= G_CLOSED;
         cnt_q <= 3'h0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   assign gif.io_open = (st_q == G_IO_OPEN);
   assign gif.spm_open = (st_q == G_SPM_OPEN);

   a_window_bound: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q != G_CLOSED) |-> (cnt_q < WINDOW_CYCLES)) else $error("unlock window overran");
endmodule // crm_guard_window
`default_nettype wire

// File: core/crm_core_regs.sv
// Core system registers, unlock guard and data space decoder
// Overview of operation
// - Signature 0xD8 opens four-cycle protected write window
// - Interrupts ignored while unlock window open
// - Guard bit 0 reads one while unlocked
// - Signature 0xE7 sets guard bit 1, four cycles
// - Guard bits 0,1 read-only, rest write-only
// - Stack pointer low/high bytes, high bits zero
// - Port offsets 0x00-0x3F, data space plus 0x20
// - Global enable cleared on irq, set on return
// - Global enable clear blocks every interrupt
// - Status bit 6 is bit copy flag
// - Sign flag equals negative xor overflow
// - ALU results update H, V, N, Z, C
// - Flash is 512 words, 9-bit word address
// - Flash mapped into data space at 0x4000
// - I/O locations then 32 bytes of SRAM
// - Lock bits and mapped flash read-only
// - Three pointer pairs with pre-decrement, post-increment
// - Direct addressing limited to 0x0040-0x00BF
// - Data access completes in two cycles
// - Bit set/clear on 0x00-0x1F except 0x08-0x0F, single bit only
// - Sixteen-bit writes low first, committed on high
`timescale 1ns/100ps
`default_nettype none
module crm_core_regs import crm_pkg::*; #(
   parameter int SRAM_BYTES = 32
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic ACC_VALID_I,
   input wire logic ACC_WE_I,
   input wire logic ACC_IO_I,
   input wire logic ACC_IND_I,
   input wire logic [1:0] ACC_PTR_I,
   input wire logic ACC_PREDEC_I,
   input wire logic ACC_POSTINC_I,
   input wire logic ACC_BIT_I,
   input wire logic ACC_BIT_SET_I,
   input wire logic [2:0] ACC_BIT_NUM_I,
   input wire logic [15:0] ACC_ADDR_I,
   input wire logic [7:0] ACC_WDATA_I,
   output logic [7:0] ACC_RDATA_O,
   output logic ACC_READY_O,
   output logic ACC_ERR_O,
   input wire logic INSTR_TICK_I,
   input wire logic IRQ_TAKEN_I,
   input wire logic IRQ_RETURN_I,
   input wire logic IRQ_ON_I,
   input wire logic IRQ_OFF_I,
   output logic IRQ_ALLOW_O,
   input wire logic [7:0] ALU_UPD_I,
   input wire logic [7:0] ALU_FLAGS_I,
   input wire logic FLAG_COPY_FROM_REG_I,
   input wire logic FLAG_COPY_BIT_I,
   input wire logic PTR_WE_I,
   input wire logic [1:0] PTR_SEL_I,
   input wire logic [15:0] PTR_WDATA_I,
   output logic [47:0] PTRS_O,
   output logic [7:0] STATUS_O,
   output logic [15:0] SP_O,
   output logic [2:0] PROT_WE_O,
   output logic [7:0] PROT_WDATA_O,
   output logic SPM_ARMED_O,
   output logic [5:0] IO_RADDR_O,
   input wire logic [7:0] IO_RDATA_I,
   output logic IO_WE_O,
   output logic [5:0] IO_WADDR_O,
   output logic [7:0] IO_WDATA_O,
   output logic [7:0] IO_WMASK_O,
   output logic [PC_WIDTH-1:0] FLASH_ADDR_O,
   input wire logic [15:0] FLASH_RDATA_I,
   input wire logic [7:0] LOCK_BITS_I
);
   crm_guard_if gif ();

   crm_guard_window u_guard (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .gif(gif.window)
   );

   crm_acc_state_t acc_q, acc_d;
   logic [7:0] rdata_q, rdata_d;
   logic err_q, err_d;
   logic [7:0] status_q, status_d;
   logic [15:0] sp_q, sp_d;
   logic [7:0] temp_q, temp_d;
   logic [15:0] ptr_q [3];
   logic [15:0] ptr_d [3];
   logic [7:0] mem_q [SRAM_BYTES];
   logic [2:0] prot_we_q, prot_we_d;
   logic [7:0] prot_wdata_q, prot_wdata_d;
   logic io_we_q, io_we_d;
   logic [5:0] io_waddr_q, io_waddr_d;
   logic [7:0] io_wdata_q, io_wdata_d;
   logic [7:0] io_wmask_q, io_wmask_d;

   logic take, is_io, is_sram, is_flash, is_lock, refused, unlocked, status_wr;
   logic [15:0] eff, ptr_sel;
   logic [5:0] io_idx;
   logic [4:0] sram_idx;
   logic prot_hit;
   logic [2:0] prot_sel;

   assign unlocked = gif.io_open;
   assign take = ACC_VALID_I && (acc_q == ACC_IDLE);
   assign gif.tick = INSTR_TICK_I;

   // Address decode
   always_comb begin
      ptr_sel = (ACC_PTR_I == 2'h3) ? 16'h0000 : ptr_q[ACC_PTR_I];
      eff = ACC_ADDR_I;
      if (ACC_IND_I) begin
         eff = ACC_PREDEC_I ? ptr_sel - 16'h0001 : ptr_sel;
      end
      is_io = 1'b0;
      io_idx = ACC_ADDR_I[5:0];
      if (ACC_IO_I) begin
         is_io = 1'b1;
      end else if (eff >= DATA_IO_BASE && eff <= DATA_IO_END) begin
         is_io = 1'b1;
         io_idx = 6'(eff - DATA_IO_BASE);
      end
      is_sram = !ACC_IO_I && eff >= SRAM_BASE && eff <= SRAM_END;
      sram_idx = eff[4:0];
      is_flash = !ACC_IO_I && eff >= FLASH_BASE && eff <= FLASH_END;
      is_lock = !ACC_IO_I && eff == LOCK_ADDR;
      prot_hit = 1'b1;
      case (io_idx)
         IO_MAIN_SRC: prot_sel = 3'b001;
         IO_PRESCALE: prot_sel = 3'b010;
         IO_WDOG: prot_sel = 3'b100;
         default: begin
            prot_sel = 3'b000;
            prot_hit = 1'b0;
         end
      endcase
      refused = 1'b0;
      if (!ACC_IO_I && !ACC_IND_I && (eff < DIRECT_LO || eff > DIRECT_HI)) begin
         refused = 1'b1;
      end
      if (ACC_IND_I && ACC_PTR_I == 2'h3) begin
         refused = 1'b1;
      end
      if (ACC_WE_I && (is_flash || is_lock)) begin
         refused = 1'b1;
      end
      if (ACC_BIT_I && (!ACC_IO_I || io_idx > IO_BITOP_MAX ||
                        (io_idx >= IO_SER_LO && io_idx <= IO_SER_HI))) begin
         refused = 1'b1;
      end
   end

   // Flash read port: word address, byte picked by address bit 0
   assign FLASH_ADDR_O = eff[PC_WIDTH:1];
   assign IO_RADDR_O = io_idx;
   assign gif.wr = take && !refused && ACC_WE_I && !ACC_BIT_I && is_io && io_idx == IO_GUARD;
   assign gif.wdata = ACC_WDATA_I;
   assign status_wr = take && !refused && ACC_WE_I && !ACC_BIT_I && is_io && io_idx == IO_STATUS;

   // Access sequencer, register writes and read mux
   always_comb begin
      acc_d = acc_q;
      rdata_d = rdata_q;
      err_d = err_q;
      sp_d = sp_q;
      temp_d = temp_q;
      prot_we_d = 3'b000;
      prot_wdata_d = prot_wdata_q;
      io_we_d = 1'b0;
      io_waddr_d = io_waddr_q;
      io_wdata_d = io_wdata_q;
      io_wmask_d = io_wmask_q;
      for (int i = 0; i < 3; i++) begin
         ptr_d[i] = ptr_q[i];
      end
      if (PTR_WE_I && PTR_SEL_I != 2'h3) begin
         ptr_d[PTR_SEL_I] = PTR_WDATA_I;
      end
      case (acc_q)
         ACC_IDLE: begin
            if (take) begin
               acc_d = ACC_DONE;
               err_d = refused;
               rdata_d = 8'h00;
               if (ACC_IND_I && !refused) begin
                  if (ACC_PREDEC_I) begin
                     ptr_d[ACC_PTR_I] = eff;
                  end else if (ACC_POSTINC_I) begin
                     ptr_d[ACC_PTR_I] = eff + 16'h0001;
                  end
               end
               if (!refused && ACC_BIT_I) begin
                  // Only the addressed bit is touched, so clear-on-one flags survive
                  io_we_d = 1'b1;
                  io_waddr_d = io_idx;
                  io_wmask_d = 8'h01 << ACC_BIT_NUM_I;
                  io_wdata_d = ACC_BIT_SET_I ? (8'h01 << ACC_BIT_NUM_I) : 8'h00;
               end else if (!refused && ACC_WE_I && is_io) begin
                  case (io_idx)
                     IO_GUARD: begin
                     end
                     IO_SP_LO: temp_d = ACC_WDATA_I;
                     IO_SP_HI: sp_d = {ACC_WDATA_I, temp_q} & SP_MASK;
                     IO_STATUS: begin
                     end
                     default: begin
                        if (prot_hit) begin
                           prot_we_d = unlocked ? prot_sel : 3'b000;
                           prot_wdata_d = ACC_WDATA_I;
                        end else begin
                           io_we_d = 1'b1;
                           io_waddr_d = io_idx;
                           io_wdata_d = ACC_WDATA_I;
                           io_wmask_d = 8'hFF;
                        end
                     end
                  endcase
               end else if (!refused && !ACC_WE_I) begin
                  if (is_io) begin
                     case (io_idx)
                        IO_GUARD: rdata_d = {6'h00, gif.spm_open, gif.io_open};
                        IO_SP_LO: begin
                           rdata_d = sp_q[7:0];
                           temp_d = sp_q[15:8];
                        end
                        IO_SP_HI: rdata_d = temp_q;
                        IO_STATUS: rdata_d = status_q;
                        default: rdata_d = IO_RDATA_I;
                     endcase
                  end else if (is_sram) begin
                     rdata_d = mem_q[sram_idx];
                  end else if (is_flash) begin
                     rdata_d = eff[0] ? FLASH_RDATA_I[15:8] : FLASH_RDATA_I[7:0];
                  end else if (is_lock) begin
                     rdata_d = LOCK_BITS_I;
                  end
               end
            end
         end
         ACC_DONE: acc_d = ACC_IDLE;
         default: acc_d = ACC_IDLE;
      endcase
   end

   // Status flags; hardware events applied after a software write
   always_comb begin
      status_d = status_q;
      if (status_wr) begin
         status_d = ACC_WDATA_I;
      end
      status_d = (status_d & ~(ALU_UPD_I & ALU_FLAG_MASK)) | (ALU_FLAGS_I & ALU_UPD_I & ALU_FLAG_MASK);
      if (FLAG_COPY_FROM_REG_I) begin
         status_d[FLG_T] = FLAG_COPY_BIT_I;
      end
      if (IRQ_TAKEN_I || IRQ_OFF_I) begin
         status_d[FLG_I] = 1'b0;
      end
      if (IRQ_RETURN_I || IRQ_ON_I) begin
         status_d[FLG_I] = 1'b1;
      end
      status_d[FLG_S] = status_d[FLG_N] ^ status_d[FLG_V];
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         acc_q <= ACC_IDLE;
         rdata_q <= 8'h00;
         err_q <= 1'b0;
         status_q <= STATUS_RESET;
         sp_q <= SP_RESET;
         temp_q <= 8'h00;
         prot_we_q <= 3'b000;
         prot_wdata_q <= 8'h00;
         io_we_q <= 1'b0;
         io_waddr_q <= 6'h00;
         io_wdata_q <= 8'h00;
         io_wmask_q <= 8'h00;
         for (int i = 0; i < 3; i++) begin
            ptr_q[i] <= 16'h0000;
         end
      end else begin
         acc_q <= acc_d;
         rdata_q <= rdata_d;
         err_q <= err_d;
         status_q <= status_d;
         sp_q <= sp_d;
         temp_q <= temp_d;
         prot_we_q <= prot_we_d;
         prot_wdata_q <= prot_wdata_d;
         io_we_q <= io_we_d;
         io_waddr_q <= io_waddr_d;
         io_wdata_q <= io_wdata_d;
         io_wmask_q <= io_wmask_d;
         for (int i = 0; i < 3; i++) begin
            ptr_q[i] <= ptr_d[i];
         end
      end
   end

   // SRAM contents are not reset, as in real silicon
   always_ff @(posedge CORE_CLK_I) begin
      if (take && !refused && ACC_WE_I && !ACC_BIT_I && is_sram) begin
         mem_q[sram_idx] <= ACC_WDATA_I;
      end
   end

   assign ACC_RDATA_O = rdata_q;
   assign ACC_READY_O = (acc_q == ACC_DONE);
   assign ACC_ERR_O = (acc_q == ACC_DONE) && err_q;
   // Window and global enable both hold interrupts off
   assign IRQ_ALLOW_O = status_q[FLG_I] && !gif.io_open && !gif.spm_open;
   assign STATUS_O = status_q;
   assign SP_O = sp_q;
   assign PTRS_O = {ptr_q[2], ptr_q[1], ptr_q[0]};
   assign PROT_WE_O = prot_we_q;
   assign PROT_WDATA_O = prot_wdata_q;
   assign SPM_ARMED_O = gif.spm_open;
   assign IO_WE_O = io_we_q;
   assign IO_WADDR_O = io_waddr_q;
   assign IO_WDATA_O = io_wdata_q;
   assign IO_WMASK_O = io_wmask_q;

   a_prot_gated: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      (PROT_WE_O != 3'b000) |-> $past(gif.io_open)) else $error("protected write while locked");
   a_irq_window: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      (gif.io_open || gif.spm_open) |-> !IRQ_ALLOW_O) else $error("irq allowed in window");
   a_gie_block: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      !STATUS_O[7] |-> !IRQ_ALLOW_O) else $error("irq allowed with enable clear");
   a_irq_clears: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      (IRQ_TAKEN_I && !IRQ_ON_I && !IRQ_RETURN_I) |=> !STATUS_O[7]) else $error("enable not cleared");
   a_sign_xor: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      STATUS_O[4] == (STATUS_O[2] ^ STATUS_O[3])) else $error("sign flag mismatch");
   a_copy_flag: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      FLAG_COPY_FROM_REG_I |=> STATUS_O[6] == $past(FLAG_COPY_BIT_I)) else $error("copy flag wrong");
   a_two_cycle: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      (ACC_VALID_I && !ACC_READY_O) |=> ACC_READY_O ##1 !ACC_READY_O) else $error("access not two cycles");
   a_sp_high_zero: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      SP_O[15:7] == 9'h000) else $error("stack pointer high bits set");
   a_flash_ro: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      (take && ACC_WE_I && !ACC_IO_I && ACC_IND_I && ACC_PTR_I != 2'h3 && eff >= FLASH_BASE &&
       eff <= FLASH_END) |=> ACC_ERR_O)
      else $error("flash write not refused");
   a_guard_spm_read: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
      (take && !refused && !ACC_WE_I && is_io && io_idx == IO_GUARD && gif.spm_open) |=> (ACC_RDATA_O == 8'h02))
      else $error("guard read wrong in self-program window");
   c_prot_write: cover property (@(posedge CORE_CLK_I) disable iff (RST_I) PROT_WE_O != 3'b000);
   c_spm_armed: cover property (@(posedge CORE_CLK_I) disable iff (RST_I) $rose(SPM_ARMED_O));
   c_bit_op: cover property (@(posedge CORE_CLK_I) disable iff (RST_I) IO_WE_O && IO_WMASK_O != 8'hFF);
   c_refused: cover property (@(posedge CORE_CLK_I) disable iff (RST_I) ACC_ERR_O);
endmodule // crm_core_regs
`default_nettype wire

// File: verification/crm_core_regs_tb_top.sv
// Self-checking bench for the core register bank and data map
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module crm_core_regs_tb_top import crm_pkg::*; ;
   // Kind bits: {write, port, indirect, predec, postinc, bitop}
   localparam logic [5:0] K_RI = 6'h10, K_WI = 6'h30, K_RD = 6'h00, K_WD = 6'h20, K_BIT = 6'h31;
   localparam logic [5:0] K_RN = 6'h08, K_RP = 6'h0A, K_RM = 6'h0C, K_WN = 6'h28;
   logic clk = 1'b0, rst = 1'b1;
   logic acc_valid = 1'b0, acc_we = 1'b0, acc_io = 1'b0, acc_ind = 1'b0, acc_predec = 1'b0, acc_postinc = 1'b0;
   logic acc_bit = 1'b0, acc_bit_set = 1'b0, instr_tick = 1'b0, irq_taken = 1'b0, irq_return = 1'b0;
   logic irq_on = 1'b0, irq_off = 1'b0, copy_en = 1'b0, copy_bit = 1'b0, ptr_we = 1'b0;
   logic [1:0] acc_ptr = 2'h0, ptr_sel = 2'h0;
   logic [2:0] acc_bit_num = 3'h0;
   logic [15:0] acc_addr = 16'h0000, ptr_wdata = 16'h0000;
   logic [7:0] acc_wdata = 8'h00, alu_upd = 8'h00, alu_flags = 8'h00, lock_bits = 8'h00;
   logic [7:0] acc_rdata, status, prot_wdata, io_rdata, io_wdata, io_wmask;
   logic acc_ready, acc_err, irq_allow, spm_armed, io_we;
   logic [47:0] ptrs;
   logic [15:0] sp, flash_rdata;
   logic [2:0] prot_we;
   logic [5:0] io_raddr, io_waddr;
   logic [8:0] flash_addr;
   int err_count = 0, comparisons = 0, n;
   logic [31:0] seed = 32'h900D;
   logic [7:0] st, rd, iwd, imask, m, mem [0:31];
   logic [2:0] pwe;
   logic [5:0] iwa;
   logic er, iwe;
   int adr [$];

   always #5 clk = ~clk;
   // Peripheral and flash read paths answer combinationally from the address
   assign io_rdata = {2'b00, io_raddr} ^ 8'h5A;
   assign flash_rdata = {7'h00, flash_addr} ^ 16'hC3A5;

   crm_core_regs dut_u (.CORE_CLK_I(clk), .RST_I(rst), .ACC_VALID_I(acc_valid), .ACC_WE_I(acc_we),
      .ACC_IO_I(acc_io), .ACC_IND_I(acc_ind), .ACC_PTR_I(acc_ptr), .ACC_PREDEC_I(acc_predec),
      .ACC_POSTINC_I(acc_postinc), .ACC_BIT_I(acc_bit), .ACC_BIT_SET_I(acc_bit_set), .ACC_BIT_NUM_I(acc_bit_num),
      .ACC_ADDR_I(acc_addr), .ACC_WDATA_I(acc_wdata), .ACC_RDATA_O(acc_rdata), .ACC_READY_O(acc_ready),
      .ACC_ERR_O(acc_err), .INSTR_TICK_I(instr_tick), .IRQ_TAKEN_I(irq_taken), .IRQ_RETURN_I(irq_return),
      .IRQ_ON_I(irq_on), .IRQ_OFF_I(irq_off), .IRQ_ALLOW_O(irq_allow), .ALU_UPD_I(alu_upd), .ALU_FLAGS_I(alu_flags),
      .FLAG_COPY_FROM_REG_I(copy_en), .FLAG_COPY_BIT_I(copy_bit), .PTR_WE_I(ptr_we), .PTR_SEL_I(ptr_sel),
      .PTR_WDATA_I(ptr_wdata), .PTRS_O(ptrs), .STATUS_O(status), .SP_O(sp), .PROT_WE_O(prot_we),
      .PROT_WDATA_O(prot_wdata), .SPM_ARMED_O(spm_armed), .IO_RADDR_O(io_raddr), .IO_RDATA_I(io_rdata),
      .IO_WE_O(io_we), .IO_WADDR_O(io_waddr), .IO_WDATA_O(io_wdata), .IO_WMASK_O(io_wmask),
      .FLASH_ADDR_O(flash_addr), .FLASH_RDATA_I(flash_rdata), .LOCK_BITS_I(lock_bits));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic step();
      @(posedge clk);
      #1;
   endtask

   task automatic pls(ref logic s);
      step();
      s = 1'b1;
      step();
      s = 1'b0;
   endtask

   // One bus access; strobes are captured in the answer cycle, where they stand
   task automatic acc(input logic [5:0] k, input logic [1:0] p, input logic [15:0] a, input logic [7:0] d);
      step();
      {acc_we, acc_io, acc_ind, acc_predec, acc_postinc, acc_bit} = k;
      acc_ptr = p;
      acc_addr = a;
      acc_wdata = d;
      acc_bit_set = d[7];
      acc_bit_num = d[2:0];
      acc_valid = 1'b1;
      n = 0;
      do begin
         step();
         n++;
      end while (acc_ready !== 1'b1 && n < 20);
      {rd, er, pwe, iwe, iwa, iwd, imask} = {acc_rdata, acc_err, prot_we, io_we, io_waddr, io_wdata, io_wmask};
      acc_valid = 1'b0;
      `CHK(n, 1)
   endtask

   task automatic ptr(input logic [1:0] s, input logic [15:0] v);
      step();
      {ptr_we, ptr_sel, ptr_wdata} = {1'b1, s, v};
      step();
      ptr_we = 1'b0;
   endtask

   task automatic results();
      $display("Comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      err_count++;
      results();
   end

   initial begin
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      `CHK(status, 8'h00)
      `CHK(sp, SP_RESET)
      `CHK(irq_allow, 1'b0)
      acc(K_RI, 0, 16'h003D, 0); `CHK(rd, 8'h5F)
      acc(K_RI, 0, 16'h003E, 0); `CHK(rd, 8'h00)
      acc(K_RI, 0, 16'h003C, 0); `CHK(rd, 8'h00)
      // Low byte alone must not move the pointer
      acc(K_WI, 0, 16'h003D, 8'hA5); `CHK(sp, SP_RESET)
      acc(K_WI, 0, 16'h003E, 8'hFF); `CHK(sp, 16'h0025)
      acc(K_WD, 0, 16'h005D, 8'h33);
      acc(K_WD, 0, 16'h005E, 8'h00); `CHK(sp, 16'h0033)
      acc(K_RD, 0, 16'h005D, 0); `CHK(rd, 8'h33)
      // Status write; sign flag is recomputed from N and V
      acc(K_WD, 0, 16'h005F, 8'hFF); st = 8'hEF; `CHK(status, st)
      acc(K_RI, 0, 16'h003F, 0); `CHK(rd, st)
      // Protected writes: closed window, wrong signature, then open window
      acc(K_WI, 0, 16'h0037, 8'h11); `CHK(pwe, 3'b000)
      acc(K_WI, 0, 16'h003C, 8'h55);
      acc(K_WI, 0, 16'h0036, 8'h11); `CHK(pwe, 3'b000)
      acc(K_WI, 0, 16'h003C, SIG_PROT_IO);
      acc(K_RI, 0, 16'h003C, 0); `CHK(rd, 8'h01)
      `CHK(irq_allow, 1'b0)
      for (int i = 0; i < 3; i++) begin
         m = 8'h40 + 8'(i);
         acc(K_WI, 0, {10'h000, i == 0 ? IO_MAIN_SRC : i == 1 ? IO_PRESCALE : IO_WDOG}, m);
         `CHK(pwe, 3'(1 << i))
         `CHK(prot_wdata, m)
      end
      repeat (3) pls(instr_tick);
      acc(K_RI, 0, 16'h003C, 0); `CHK(rd, 8'h01)
      pls(instr_tick);
      acc(K_RI, 0, 16'h003C, 0); `CHK(rd, 8'h00)
      `CHK(irq_allow, 1'b1)
      acc(K_WI, 0, 16'h0031, 8'h22); `CHK(pwe, 3'b000)
      acc(K_WD, 0, 16'h005C, SIG_SELF_PROG);
      acc(K_RI, 0, 16'h003C, 0); `CHK(rd, 8'h02)
      repeat (3) pls(instr_tick);
      `CHK(spm_armed, 1'b1)
      pls(instr_tick);
      step(); `CHK(spm_armed, 1'b0)
      pls(irq_taken); st[7] = 1'b0; `CHK(status, st)
      `CHK(irq_allow, 1'b0)
      pls(irq_return); st[7] = 1'b1; `CHK(status, st)
      pls(irq_off); st[7] = 1'b0; `CHK(status, st)
      pls(irq_on); st[7] = 1'b1; `CHK(irq_allow, 1'b1)
      repeat (16) begin
         seed = lfsr(seed);
         step();
         {alu_upd, alu_flags, copy_bit, copy_en} = {seed[15:0], seed[16], seed[17]};
         step();
         {alu_upd, copy_en} = 9'h000;
         m = seed[15:8] & ALU_FLAG_MASK;
         st = (st & ~m) | (seed[7:0] & m);
         if (seed[17]) st[6] = seed[16];
         st[4] = st[2] ^ st[3];
         `CHK(status, st)
      end
      // SRAM through direct addressing
      repeat (8) begin
         seed = lfsr(seed);
         adr.push_back(32'(seed[4:0]));
         mem[seed[4:0]] = seed[15:8];
         acc(K_WD, 0, SRAM_BASE + 16'(seed[4:0]), seed[15:8]);
      end
      foreach (adr[i]) begin
         acc(K_RD, 0, SRAM_BASE + 16'(adr[i]), 0); `CHK(rd, mem[adr[i]])
      end
      acc(K_RD, 0, 16'h0080, 0); `CHK(rd, 8'h00)
      acc(K_RD, 0, 16'h003F, 0); `CHK(er, 1'b1)
      acc(K_RD, 0, 16'h00C0, 0); `CHK(er, 1'b1)
      acc(K_RD, 0, DIRECT_HI, 0); `CHK(er, 1'b0)
      ptr(2, 16'h4003);
      acc(K_RP, 2, 0, 0); `CHK(rd, 8'hC3)
      `CHK(ptrs[47:32], 16'h4004)
      ptr(0, FLASH_END);
      acc(K_RP, 0, 0, 0); `CHK(rd, 8'hC2)
      seed = lfsr(seed);
      lock_bits = seed[7:0];
      ptr(1, 16'h3F01);
      acc(K_RM, 1, 0, 0); `CHK(rd, seed[7:0])
      `CHK(ptrs[31:16], LOCK_ADDR)
      acc(K_WN, 1, 0, 8'h00); `CHK(er, 1'b1)
      ptr(0, 16'h4010);
      acc(K_WN, 0, 0, 8'h00); `CHK(er, 1'b1)
      acc(K_RN, 3, 0, 0); `CHK(er, 1'b1)
      ptr(0, 16'h0025);
      acc(K_RN, 0, 0, 0); `CHK(rd, 8'h5F)
      acc(K_WI, 0, 16'h0010, 8'h3C); `CHK({iwe, iwa, iwd, imask}, {1'b1, 6'h10, 8'h3C, 8'hFF})
      for (int b = 0; b < 16; b++) begin
         acc(K_BIT, 0, 16'h001F, {b[3], 4'h0, b[2:0]});
         `CHK({iwe, iwa, imask, iwd[b[2:0]]}, {1'b1, 6'h1F, 8'(1 << b[2:0]), b[3]})
      end
      acc(K_BIT, 0, 16'h000A, 8'h81); `CHK({er, iwe}, 2'b10)
      acc(K_BIT, 0, 16'h0020, 8'h81); `CHK({er, iwe}, 2'b10)
      // Second reset in mid-run
      step();
      rst = 1'b1;
      step();
      rst = 1'b0;
      `CHK({status, sp, spm_armed}, {8'h00, SP_RESET, 1'b0})
      results();
   end
endmodule // crm_core_regs_tb_top
`default_nettype wire
